// ==== flash_param_params.svh ====
// constants for the flash programming parameter checker
// assumes inclusion from the package of this block
`ifndef FLASH_PARAM_PARAMS_SVH
`define FLASH_PARAM_PARAMS_SVH
`define KEY_MSB           31
`define KEY_LSB           16
`define FREQ_MSB          15
`define FREQ_LSB          0
`define BRANCH_KEY_ON     16'hAA55
`define BRANCH_KEY_OFF    16'h0000
`define FREQ_MIN_MHZ      8
`define FREQ_MAX_MHZ      40
`define FREQ_UNITS_PER_MHZ 100
`define FREQ_CODE_MIN     16'h0320
`define FREQ_CODE_MAX     16'h0FA0
`define ALIGN_LOW_BITS    7
`define UNIT_BYTES        128
`define FLASH_BASE        32'h0000_0000
`define FLASH_LIMIT       32'h0003_FFFF
`define RES_FAIL_BIT      0
`define RES_FREQ_BIT      1
`define RES_WA_BIT        7
`define RES_KEY_BIT       8
`define WORD_ADDR_STEP    32'h0000_0004
`endif

// ==== flash_param_pkg.sv ====
// types shared by the flash programming parameter checker
// assumes the params header sits in the same folder
package flash_param_pkg;
  `include "flash_param_params.svh"
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_WRITE = 2'b11,
    ST_DONE  = 2'b10
  } seq_state_t;
endpackage : flash_param_pkg

// ==== dest_address_check.sv ====
// range and alignment check of a programming destination address
// assumes a synchronous environment; result is registered
`timescale 1ns/100ps
module dest_address_check
  import flash_param_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // address in
  input  wire logic [31:0] address_i,
  // verdict
  output logic             address_error_o
);
  typedef struct packed {
    logic err;
  } chk_state_t;
  chk_state_t st;
  chk_state_t next_st;

  // unit end must stay inside the array too
  function automatic logic bad_address(input logic [31:0] a);
    logic [32:0] last;
    last = {1'b0, a} + 33'(`UNIT_BYTES - 1);
    bad_address = (a < `FLASH_BASE) || (last > {1'b0, `FLASH_LIMIT})
                  || (a[`ALIGN_LOW_BITS-1:0] != 7'h00);
  endfunction : bad_address

  // combinational verdict
  always_comb begin
    next_st.err = bad_address(address_i);
  end

  // register verdict
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign address_error_o = st.err;
endmodule : dest_address_check

// ==== flash_program_param_check.sv ====
// parameter intake, validation and 128-byte write sequencing for flash programming
// assumes the cpu presents both parameter words with a start pulse and
// that the flash array accepts one byte per cycle while ready is high
//
// Operation
// - key AA55 enables branch, else 0000
// - low half is frequency in 0.01 MHz
// - full 32-bit word is destination start
// - out-of-flash destination sets address error
// - unaligned destination sets address error
// - each accepted operation writes 128 consecutive bytes, a rejected one writes none
// - destination bits 6 to 0 zero
`timescale 1ns/100ps
module flash_program_param_check
  import flash_param_pkg::*;
(
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // cpu parameter registers
  input  wire logic [31:0] cpu_general_reg_0_i,
  input  wire logic [31:0] cpu_general_reg_1_i,
  input  wire logic        start_i,
  // data byte source
  input  wire logic [7:0]  source_byte_i,
  // flash array side
  input  wire logic        flash_ready_i,
  output logic             flash_write_o,
  output logic [31:0]      flash_address_o,
  output logic [7:0]       flash_data_o,
  // result to cpu
  output logic [31:0]      program_result_word_o,
  output logic             user_branch_enable_o,
  output logic             busy_o,
  output logic             done_o
);
  typedef struct packed {
    seq_state_t  state;
    logic [31:0] program_erase_frequency_param;
    logic [31:0] program_destination_address_param;
    logic [6:0]  byte_count;
    logic        wr;
    logic [31:0] waddr;
    logic [7:0]  wdata;
    logic [31:0] result;
    logic        branch_en;
    logic        done;
    logic        busy;
  } core_state_t;
  core_state_t st;
  core_state_t next_st;
  logic        address_error;

  // checker is fed the next address, so its registered verdict is fresh in the check state
  dest_address_check u_addr_check (
    .clock_i         (clock_i),
    .rst_i           (rst_i),
    .address_i       (next_st.program_destination_address_param),
    .address_error_o (address_error)
  );

  logic [15:0] key_field;
  logic [15:0] frequency_code;
  logic        key_bad;
  logic        freq_bad;
  // key must be one of two legal values
  assign key_field      = st.program_erase_frequency_param[`KEY_MSB:`KEY_LSB];
  assign key_bad        = (key_field != `BRANCH_KEY_ON) && (key_field != `BRANCH_KEY_OFF);
  // 0.01 MHz units, range from the frequency limits
  assign frequency_code = st.program_erase_frequency_param[`FREQ_MSB:`FREQ_LSB];
  assign freq_bad       = (frequency_code < 16'(`FREQ_MIN_MHZ * `FREQ_UNITS_PER_MHZ))
                       || (frequency_code > 16'(`FREQ_MAX_MHZ * `FREQ_UNITS_PER_MHZ));

  // sequencer next state
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    next_st.wr   = 1'b0;
    unique case (st.state)
      ST_IDLE: begin
        if (start_i) begin
          next_st.program_erase_frequency_param     = cpu_general_reg_0_i;
          next_st.program_destination_address_param = cpu_general_reg_1_i;
          next_st.result                            = '0;
          next_st.state                             = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // errors end the operation before any byte is written
        if (address_error || key_bad || freq_bad) begin
          next_st.result[`RES_WA_BIT]   = address_error;
          next_st.result[`RES_KEY_BIT]  = key_bad;
          next_st.result[`RES_FREQ_BIT] = freq_bad;
          next_st.result[`RES_FAIL_BIT] = 1'b1;
          next_st.state                 = ST_DONE;
        end else begin
          next_st.branch_en  = (key_field == `BRANCH_KEY_ON);
          next_st.byte_count = 7'h00;
          next_st.state      = ST_WRITE;
        end
      end
      ST_WRITE: begin
        // one byte per ready cycle, stalls while flash is busy
        if (flash_ready_i) begin
          next_st.wr         = 1'b1;
          next_st.waddr      = st.program_destination_address_param
                               + {25'h0, st.byte_count};
          next_st.wdata      = source_byte_i;
          next_st.byte_count = st.byte_count + 7'h01;
          if (st.byte_count == 7'h7F) begin
            next_st.state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        next_st.done  = 1'b1;
        next_st.state = ST_IDLE;
      end
    endcase
    // busy registered so the output comes straight from a flop
    next_st.busy = (next_st.state != ST_IDLE);
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flash_write_o         = st.wr;
  assign flash_address_o       = st.waddr;
  assign flash_data_o          = st.wdata;
  assign program_result_word_o = st.result;
  assign user_branch_enable_o  = st.branch_en;
  assign busy_o                = st.busy;
  assign done_o                = st.done;

  // named check-state outcomes of an accepted or a rejected operation
  sequence s_accepted;
    st.state == ST_CHECK && !address_error && !key_bad && !freq_bad;
  endsequence
  sequence s_rejected;
    st.state == ST_CHECK && (address_error || key_bad || freq_bad);
  endsequence

  a_error_blocks_write: assert property (@(posedge clock_i) disable iff (rst_i)
    s_rejected |=> !flash_write_o [*2])
    else $error("write issued after a parameter error");
  a_error_sets_fail: assert property (@(posedge clock_i) disable iff (rst_i)
    s_rejected |=> program_result_word_o[`RES_FAIL_BIT] ##1 done_o)
    else $error("fail bit or done missing after error");
  a_addr_flag: assert property (@(posedge clock_i) disable iff (rst_i)
    s_rejected |=> program_result_word_o[`RES_WA_BIT] == $past(address_error))
    else $error("address error flag mismatch");
  a_unaligned_flag: assert property (@(posedge clock_i) disable iff (rst_i)
    (st.state == ST_CHECK && st.program_destination_address_param[6:0] != 7'h00)
      |=> program_result_word_o[`RES_WA_BIT])
    else $error("unaligned start not flagged");
  a_write_aligned: assert property (@(posedge clock_i) disable iff (rst_i)
    (flash_write_o && flash_address_o[6:0] == 7'h00)
      |-> st.program_destination_address_param == flash_address_o)
    else $error("first byte not at start address");
  a_write_in_unit: assert property (@(posedge clock_i) disable iff (rst_i)
    flash_write_o |-> flash_address_o[31:7] == st.program_destination_address_param[31:7])
    else $error("write left the 128-byte unit");
  a_write_start: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_accepted ##1 flash_ready_i) |=> flash_write_o
      && flash_address_o == st.program_destination_address_param)
    else $error("programming did not begin at start address");
  a_branch_key: assert property (@(posedge clock_i) disable iff (rst_i)
    s_accepted |=> user_branch_enable_o == (key_field == `BRANCH_KEY_ON))
    else $error("branch enable does not follow key");
  a_freq_range: assert property (@(posedge clock_i) disable iff (rst_i)
    (st.state == ST_CHECK && frequency_code > 16'h0FA0) |=> program_result_word_o[`RES_FREQ_BIT])
    else $error("frequency above range accepted");
  // a stalled array must not see a strobe
  a_stall_no_write: assert property (@(posedge clock_i) disable iff (rst_i)
    (st.state == ST_WRITE && !flash_ready_i) |=> !flash_write_o)
    else $error("write issued while array not ready");
  // done only once the sequencer is back in idle
  a_done_idle: assert property (@(posedge clock_i) disable iff (rst_i)
    done_o |-> !busy_o)
    else $error("done pulsed while still busy");
endmodule : flash_program_param_check

// ==== flash_array_model.sv ====
// flash array stand-in: accepts written bytes, counts them, checks order
// assumes the bench clears it in the start cycle of each operation
`timescale 1ns/100ps
module flash_array_model (
  // clock and control
  input  wire logic        clock_i,
  input  wire logic        clear_i,
  input  wire logic        stall_i,
  input  wire logic [31:0] base_i,
  // write side of the block
  input  wire logic        flash_write_i,
  input  wire logic [31:0] flash_address_i,
  input  wire logic [7:0]  flash_data_i,
  // observations
  output logic             ready_o = 1'b1,
  output int               writes_o,
  output logic             in_order_o,
  output logic [7:0]       last_data_o
);
  // a slow array drops ready every other cycle to stretch the walk
  always @(posedge clock_i) begin
    ready_o <= stall_i ? ~ready_o : 1'b1;
    if (clear_i) begin
      writes_o   <= 0;
      in_order_o <= 1'b1;
    end else if (flash_write_i) begin
      // byte k must land at start plus k
      if (flash_address_i !== base_i + writes_o) in_order_o <= 1'b0;
      writes_o    <= writes_o + 1;
      last_data_o <= flash_data_i;
    end
  end
endmodule : flash_array_model

// ==== flash_program_param_check_tb.sv ====
// bench for the flash programming parameter checker
// assumes the flash array model is compiled before it
`timescale 1ns/100ps
module flash_program_param_check_tb;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic [31:0] reg0    = 32'h0;
  logic [31:0] reg1    = 32'h0;
  logic        start   = 1'b0;
  logic [7:0]  src     = 8'h00;
  logic        clear   = 1'b1;
  logic        stall   = 1'b0;
  logic [31:0] base    = 32'h0;
  logic        ready, fwr, branch, busy, done, in_order;
  logic [31:0] faddr, result;
  logic [7:0]  fdata, last_data;
  int          writes, n_errors = 0, compares = 0;
  logic        branch_exp = 1'b0;

  flash_program_param_check dut_u (.clock_i, .rst_i, .cpu_general_reg_0_i(reg0),
    .cpu_general_reg_1_i(reg1), .start_i(start), .source_byte_i(src),
    .flash_ready_i(ready), .flash_write_o(fwr), .flash_address_o(faddr),
    .flash_data_o(fdata), .program_result_word_o(result),
    .user_branch_enable_o(branch), .busy_o(busy), .done_o(done));
  flash_array_model array_u (.clock_i, .clear_i(clear), .stall_i(stall), .base_i(base),
    .flash_write_i(fwr), .flash_address_i(faddr), .flash_data_i(fdata),
    .ready_o(ready), .writes_o(writes), .in_order_o(in_order), .last_data_o(last_data));

  // 40 MHz clock
  initial forever #12.5 clock_i = ~clock_i;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // one operation: pulse start, wait bounded for done, compare everything
  task automatic op(input logic [31:0] f, input logic [31:0] a, input logic [31:0] e,
                    input logic st);
    int n;
    n = 0;
    @(posedge clock_i);
    reg0  <= f;
    reg1  <= a;
    base  <= a;
    stall <= st;
    src   <= f[7:0] ^ 8'h3C;
    start <= 1'b1;
    clear <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    clear <= 1'b0;
    while (done !== 1'b1 && n < 600) begin
      @(negedge clock_i);
      n++;
    end
    chk("done", 1, done);
    chk("result", e, result);
    chk("writes", (e === 32'h0) ? 128 : 0, writes);
    chk("in_order", 1, in_order);
    // branch enable only moves on an accepted operation
    if (e === 32'h0) branch_exp = (f[31:16] === 16'hAA55);
    chk("branch", branch_exp, branch);
    if (e === 32'h0) begin
      chk("last_addr", a + 32'h7F, faddr);
      chk("last_data", f[7:0] ^ 8'h3C, last_data);
    end
  endtask : op

  // hang guard, far beyond the longest expected run
  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    chk("idle_busy", 0, busy);
    chk("idle_result", 0, result);
    op(32'h0000_0FA0, 32'h0000_0080, 32'h0, 1'b0);
    op(32'hAA55_0320, 32'h0003_FF80, 32'h0, 1'b1);
    op(32'h0000_0FA0, 32'h0000_0081, 32'h81, 1'b0);
    op(32'h0000_0FA0, 32'h0004_0000, 32'h81, 1'b0);
    op(32'h0000_031F, 32'h0000_0000, 32'h3, 1'b0);
    op(32'h0000_0FA1, 32'h0000_0100, 32'h3, 1'b1);
    op(32'h1234_0FA0, 32'h0000_0180, 32'h101, 1'b0);
    print_verdict();
  end
endmodule : flash_program_param_check_tb
